// ---- verilog/bmm_device.sv ----
// monitor end: operating-mode state machine with its configuration registers
`timescale 1ns/1ps
`include "bmm_map.svh"
module bmm_device import bmm_pkg::*; #(
  parameter int WAKE_CYC = `BMM_WAKE_CYC,
  parameter int SEN_CYC = `BMM_SEN_CYC,
  parameter int SHUTDOWN_PIN_CYC = `BMM_SHUTDOWN_PIN_CYC
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  bmm_if.dev LINK,
  input wire logic CHARGER_DETECT_PIN_I,
  input wire logic LOAD_DETECT_PIN_I,
  input wire logic WDT_TIMEOUT_I,
  input wire logic THERMAL_SHUTDOWN_I,
  input wire logic OV_SUPPLY_5V5_I,
  input wire logic OV_SUPPLY_1V8_I,
  input wire logic UV_SUPPLY_5V5_I,
  input wire logic OV_EXTERNAL_REGULATOR_I,
  input wire logic UV_EXTERNAL_REGULATOR_I,
  output logic [2:0] MODE_O,
  output logic MEAS_EN_O,
  output logic PROT_EN_O,
  output logic FET_ON_O,
  output logic COMM_ON_O
);
  localparam int CW = `BMM_CNT_W;

  // held-level counter: saturates one below the limit
  function automatic logic [CW-1:0] held_step(input logic lvl, input logic [CW-1:0] c,
                                               input int lim);
    held_step = (lvl && c < CW'(lim - 1)) ? c + CW'(1) : (lvl ? c : '0);
  endfunction

  function automatic logic held_done(input logic lvl, input logic [CW-1:0] c, input int lim);
    held_done = lvl && c == CW'(lim - 1);
  endfunction

  bmm_mode_t mode_r, mode_nxt;
  logic [15:0] mc_r, mc_nxt, wd_r, ps_r, os_r, rp_r, rdata_r;
  logic [2:0] chg_s_r, load_s_r;
  logic [CW-1:0] chg_cnt_r, load_cnt_r, shutdown_pin_cnt_r, sen_cnt_r;
  logic clr_lp, clr_stb, clr_slp;
  logic meas_r, prot_r, fet_r, comm_r;

  // pin synchronisers; second and third stage must agree
  wire chg_hi = chg_s_r[1] & chg_s_r[2];
  wire chg_lo = ~chg_s_r[1] & ~chg_s_r[2];
  wire load_lo = ~load_s_r[1] & ~load_s_r[2];

  wire chg_fire = held_done(chg_hi, chg_cnt_r, WAKE_CYC);
  wire load_fire = held_done(load_lo, load_cnt_r, WAKE_CYC);
  wire shutdown_pin_fire = held_done(LINK.shutdown_pin, shutdown_pin_cnt_r, SHUTDOWN_PIN_CYC);
  wire sen_fire = held_done(LINK.standby_exit_pin, sen_cnt_r, SEN_CYC);

  // register port decode, only while comms are up
  wire acc_wr = LINK.reg_wr & comm_r;
  wire acc_rd = LINK.reg_rd & comm_r;
  wire hit_mc = LINK.reg_addr == `BMM_OFS_MODE_CTRL;
  wire hit_wd = LINK.reg_addr == `BMM_OFS_WDT_CTRL;
  wire hit_ps = LINK.reg_addr == `BMM_OFS_PROT_CFG;
  wire hit_os = LINK.reg_addr == `BMM_OFS_OSC_CFG;
  wire hit_rp = LINK.reg_addr == `BMM_OFS_EXTERNAL_REGULATOR_CFG;
  wire [15:0] rd_val = hit_mc ? mc_r : hit_wd ? wd_r : hit_ps ? ps_r :
                       hit_os ? os_r : hit_rp ? rp_r : 16'h0000;

  wire req_lp = mc_r[`BMM_BIT_LOW_POWER_REQ];
  wire req_stb = mc_r[`BMM_BIT_STANDBY_REQ];
  wire req_slp = mc_r[`BMM_BIT_SLEEP_REQ];
  wire req_shutdown_pin = mc_r[`BMM_BIT_SHUTDOWN_REQ];
  wire chg_lp_en = mc_r[`BMM_BIT_CHG_WAKE_LP];
  wire load_lp_en = mc_r[`BMM_BIT_LOAD_WAKE_LP];
  wire load_slp_en = mc_r[`BMM_BIT_LOAD_WAKE_SLP];
  // both sleep enables clear still leaves charger wake on
  wire chg_slp_en = mc_r[`BMM_BIT_CHG_WAKE_SLP] | ~load_slp_en;

  wire in_sleep = mode_r == BMM_SLEEP;
  wire in_stb = mode_r == BMM_STANDBY;
  wire sleep_prot = ~in_sleep | os_r[`BMM_BIT_OSC_KEEP];
  wire wdt_cause = WDT_TIMEOUT_I & wd_r[`BMM_BIT_WDT_EN] & ~in_sleep &
                   (~in_stb | wd_r[`BMM_BIT_STANDBY_WATCHDOG_ENABLE]);
  wire tsd_cause = THERMAL_SHUTDOWN_I & ~ps_r[`BMM_BIT_THERMAL_MASK] & sleep_prot;
  wire ov_cause = sleep_prot & (((OV_SUPPLY_5V5_I | OV_SUPPLY_1V8_I) &
                  ~ps_r[`BMM_BIT_CORE_OV_MASK]) |
                  (OV_EXTERNAL_REGULATOR_I & ~rp_r[`BMM_BIT_EXTREG_OV_MASK]));
  wire uv_cause = UV_SUPPLY_5V5_I |
                  (UV_EXTERNAL_REGULATOR_I & ~rp_r[`BMM_BIT_EXTREG_UV_MASK]);
  // automatic causes and the request bit only with no charger present
  wire auto_shutdown_pin = chg_lo & (wdt_cause | tsd_cause | ov_cause | uv_cause);
  wire req_shutdown_pin_ok = chg_lo & req_shutdown_pin & ~in_stb & ~in_sleep;
  wire go_shutdown_pin = shutdown_pin_fire | auto_shutdown_pin | req_shutdown_pin_ok;
  wire lp_wake = (chg_fire & chg_lp_en) | (load_fire & load_lp_en);
  wire slp_wake = (chg_fire & chg_slp_en) | (load_fire & load_slp_en);

  always_comb begin
    mode_nxt = mode_r;
    clr_lp = 1'b0;
    clr_stb = 1'b0;
    clr_slp = 1'b0;
    unique case (mode_r)
      BMM_ACTIVE: begin
        if (go_shutdown_pin) begin
          mode_nxt = BMM_SHUTDOWN;
        end else if (req_lp) begin
          mode_nxt = BMM_LOW_POWER;
        end else if (req_stb) begin
          mode_nxt = BMM_STANDBY;
        end else if (req_slp) begin
          mode_nxt = BMM_SLEEP;
        end
      end
      BMM_LOW_POWER: begin
        if (go_shutdown_pin) begin
          mode_nxt = BMM_SHUTDOWN;
        end else if (!req_lp) begin
          mode_nxt = BMM_ACTIVE;
        end else if (lp_wake) begin
          mode_nxt = BMM_ACTIVE;
          clr_lp = 1'b1;
        end
      end
      BMM_STANDBY: begin
        if (go_shutdown_pin) begin
          mode_nxt = BMM_SHUTDOWN;
        end else if (sen_fire || lp_wake) begin
          mode_nxt = BMM_ACTIVE;
          clr_stb = 1'b1;
        end
      end
      BMM_SLEEP: begin
        if (go_shutdown_pin) begin
          mode_nxt = BMM_SHUTDOWN;
        end else if (slp_wake) begin
          mode_nxt = BMM_ACTIVE;
          clr_slp = 1'b1;
        end
      end
      BMM_SHUTDOWN: begin
        mode_nxt = BMM_SHUTDOWN;
      end
      default: begin
        mode_nxt = BMM_SHUTDOWN;
      end
    endcase
  end

  // software write wins over a hardware clear in the same cycle
  always_comb begin
    mc_nxt = mc_r;
    if (acc_wr && hit_mc) begin
      mc_nxt = LINK.reg_wdata;
    end else begin
      if (clr_lp) mc_nxt[`BMM_BIT_LOW_POWER_REQ] = 1'b0;
      if (clr_stb) mc_nxt[`BMM_BIT_STANDBY_REQ] = 1'b0;
      if (clr_slp) mc_nxt[`BMM_BIT_SLEEP_REQ] = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      chg_s_r <= 3'h0;
      load_s_r <= 3'h7;
      chg_cnt_r <= '0;
      load_cnt_r <= '0;
      shutdown_pin_cnt_r <= '0;
      sen_cnt_r <= '0;
    end else begin
      chg_s_r <= {chg_s_r[1:0], CHARGER_DETECT_PIN_I};
      load_s_r <= {load_s_r[1:0], LOAD_DETECT_PIN_I};
      chg_cnt_r <= held_step(chg_hi, chg_cnt_r, WAKE_CYC);
      load_cnt_r <= held_step(load_lo, load_cnt_r, WAKE_CYC);
      shutdown_pin_cnt_r <= held_step(LINK.shutdown_pin, shutdown_pin_cnt_r, SHUTDOWN_PIN_CYC);
      sen_cnt_r <= held_step(LINK.standby_exit_pin, sen_cnt_r, SEN_CYC);
    end
  end

  // registers change only by writes and reset, except the mode request bits that a wake clears
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mc_r <= `BMM_RST_MODE_CTRL;
      wd_r <= `BMM_RST_WDT_CTRL;
      ps_r <= `BMM_RST_PROT_CFG;
      os_r <= `BMM_RST_OSC_CFG;
      rp_r <= `BMM_RST_EXTERNAL_REGULATOR_CFG;
      rdata_r <= 16'h0000;
    end else begin
      mc_r <= mc_nxt;
      if (acc_wr && hit_wd) wd_r <= LINK.reg_wdata;
      if (acc_wr && hit_ps) ps_r <= LINK.reg_wdata;
      if (acc_wr && hit_os) os_r <= LINK.reg_wdata;
      if (acc_wr && hit_rp) rp_r <= LINK.reg_wdata;
      rdata_r <= acc_rd ? rd_val : 16'h0000;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      mode_r <= BMM_ACTIVE;
      meas_r <= 1'b1;
      prot_r <= 1'b1;
      fet_r <= 1'b1;
      comm_r <= 1'b1;
    end else begin
      mode_r <= mode_nxt;
      meas_r <= mode_nxt == BMM_ACTIVE || mode_nxt == BMM_LOW_POWER;
      prot_r <= mode_nxt != BMM_SLEEP && mode_nxt != BMM_SHUTDOWN;
      fet_r <= mode_nxt != BMM_SLEEP && mode_nxt != BMM_SHUTDOWN;
      comm_r <= mode_nxt == BMM_ACTIVE || mode_nxt == BMM_LOW_POWER;
    end
  end

  assign LINK.reg_rdata = rdata_r;
  assign LINK.comm_on = comm_r;
  assign LINK.dev_mode = mode_r;
  assign MODE_O = mode_r;
  assign MEAS_EN_O = meas_r;
  assign PROT_EN_O = prot_r;
  assign FET_ON_O = fet_r;
  assign COMM_ON_O = comm_r;
endmodule

// ---- verilog/bmm_map.svh ----
// offsets, field positions, reset values and timing counts of the mode block
`ifndef BMM_MAP_SVH
`define BMM_MAP_SVH

`define BMM_ADDR_W 8
`define BMM_DATA_W 16
`define BMM_OFS_MODE_CTRL 8'h01
`define BMM_OFS_WDT_CTRL 8'h03
`define BMM_OFS_PROT_CFG 8'h11
`define BMM_OFS_OSC_CFG 8'h17
`define BMM_OFS_EXTERNAL_REGULATOR_CFG 8'h20
`define BMM_OFS_HOST_CTRL 8'h80
`define BMM_OFS_HOST_STAT 8'h81

`define BMM_RST_MODE_CTRL 16'h0780
`define BMM_RST_WDT_CTRL 16'h0000
`define BMM_RST_PROT_CFG 16'h0000
`define BMM_RST_OSC_CFG 16'h0000
`define BMM_RST_EXTERNAL_REGULATOR_CFG 16'h0000

`define BMM_BIT_SHUTDOWN_REQ 1
`define BMM_BIT_SLEEP_REQ 2
`define BMM_BIT_LOW_POWER_REQ 3
`define BMM_BIT_STANDBY_REQ 4
`define BMM_BIT_CHG_WAKE_LP 7
`define BMM_BIT_LOAD_WAKE_LP 8
`define BMM_BIT_CHG_WAKE_SLP 9
`define BMM_BIT_LOAD_WAKE_SLP 10
`define BMM_BIT_WDT_EN 12
`define BMM_BIT_STANDBY_WATCHDOG_ENABLE 14
`define BMM_BIT_THERMAL_MASK 13
`define BMM_BIT_CORE_OV_MASK 14
`define BMM_BIT_EXTREG_OV_MASK 2
`define BMM_BIT_EXTREG_UV_MASK 1
`define BMM_BIT_OSC_KEEP 14
`define BMM_BIT_HOST_SEN_GO 0
`define BMM_BIT_HOST_SHUTDOWN_PIN_GO 1

`define BMM_CLK_KHZ 50000
`define BMM_WAKE_US 2000
`define BMM_SEN_US 3000
`define BMM_SHUTDOWN_PIN_US 1000
`define BMM_BOOT_US 5000
`define BMM_WAKE_CYC ((`BMM_WAKE_US * `BMM_CLK_KHZ + 999) / 1000)
`define BMM_SEN_CYC ((`BMM_SEN_US * `BMM_CLK_KHZ + 999) / 1000)
`define BMM_SHUTDOWN_PIN_CYC ((`BMM_SHUTDOWN_PIN_US * `BMM_CLK_KHZ + 999) / 1000)
`define BMM_BOOT_CYC ((`BMM_BOOT_US * `BMM_CLK_KHZ + 999) / 1000)
`define BMM_CNT_W 18

`endif

// ---- verilog/bmm_pkg.sv ----
// types shared by both ends of the mode link
package bmm_pkg;
  typedef enum logic [2:0] {
    BMM_ACTIVE = 3'b000,
    BMM_LOW_POWER = 3'b001,
    BMM_STANDBY = 3'b010,
    BMM_SLEEP = 3'b011,
    BMM_SHUTDOWN = 3'b100
  } bmm_mode_t;
endpackage

// ---- verilog/bmm_if.sv ----
// link between controller and monitor: register port, mode pins, mode status
`timescale 1ns/1ps
`include "bmm_map.svh"
interface bmm_if;
  import bmm_pkg::*;
  logic [`BMM_ADDR_W-1:0] reg_addr;
  logic [`BMM_DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [`BMM_DATA_W-1:0] reg_rdata;
  logic shutdown_pin;
  logic standby_exit_pin;
  logic comm_on;
  bmm_mode_t dev_mode;

  modport dev (
    input reg_addr, reg_wdata, reg_wr, reg_rd, shutdown_pin, standby_exit_pin,
    output reg_rdata, comm_on, dev_mode
  );
  modport host (
    output reg_addr, reg_wdata, reg_wr, reg_rd, shutdown_pin, standby_exit_pin,
    input reg_rdata, comm_on, dev_mode
  );
endinterface

// ---- verilog/bmm_host.sv ----
// controller end: forwards register access, drives mode pins, tracks readiness
`timescale 1ns/1ps
`include "bmm_map.svh"
module bmm_host import bmm_pkg::*; #(
  parameter int SEN_CYC = `BMM_SEN_CYC,
  parameter int SHUTDOWN_PIN_CYC = `BMM_SHUTDOWN_PIN_CYC,
  parameter int WAKE_CYC = `BMM_WAKE_CYC,
  parameter int BOOT_CYC = `BMM_BOOT_CYC
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  bmm_if.host LINK,
  input wire logic [7:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  output logic MEAS_READY_O
);
  localparam int CW = `BMM_CNT_W;

  logic [CW-1:0] sen_cnt_r, shutdown_pin_cnt_r, wait_cnt_r;
  logic [15:0] stat_r;
  logic dev_sel_r;
  bmm_mode_t mode_prev_r;

  wire own = ADDR_I[7];
  wire hit_ctrl = ADDR_I == `BMM_OFS_HOST_CTRL;
  wire hit_stat = ADDR_I == `BMM_OFS_HOST_STAT;
  wire ctrl_wr = WR_I & hit_ctrl;
  wire sen_go = ctrl_wr & WDATA_I[`BMM_BIT_HOST_SEN_GO];
  wire shutdown_pin_go = ctrl_wr & WDATA_I[`BMM_BIT_HOST_SHUTDOWN_PIN_GO];
  wire mc_wr = WR_I & ~own & ADDR_I == `BMM_OFS_MODE_CTRL;
  wire both_slp_off = ~WDATA_I[`BMM_BIT_CHG_WAKE_SLP] & ~WDATA_I[`BMM_BIT_LOAD_WAKE_SLP];
  wire back_active = LINK.dev_mode == BMM_ACTIVE && mode_prev_r != BMM_ACTIVE;
  wire [15:0] stat_val = {10'h000, MEAS_READY_O, sen_cnt_r != '0, shutdown_pin_cnt_r != '0,
                          LINK.dev_mode};

  // commands outside the host's own addresses (bit 7 clear) pass straight to the monitor
  assign LINK.reg_addr = ADDR_I;
  assign LINK.reg_wr = WR_I & ~own;
  assign LINK.reg_rd = RD_I & ~own;
  // never leave both sleep wake sources off
  assign LINK.reg_wdata = WDATA_I | {6'h00, mc_wr & both_slp_off, 9'h000};
  assign LINK.standby_exit_pin = sen_cnt_r != '0;
  assign LINK.shutdown_pin = shutdown_pin_cnt_r != '0;
  assign RDATA_O = dev_sel_r ? LINK.reg_rdata : stat_r;
  // low in the first active cycle, before the wake wait is loaded
  assign MEAS_READY_O = wait_cnt_r == '0 && LINK.dev_mode == BMM_ACTIVE &&
                        mode_prev_r == BMM_ACTIVE;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sen_cnt_r <= '0;
      shutdown_pin_cnt_r <= '0;
    end else begin
      // pins held one cycle beyond the monitor's count
      if (sen_go) sen_cnt_r <= CW'(SEN_CYC + 1);
      else if (sen_cnt_r != '0) sen_cnt_r <= sen_cnt_r - CW'(1);
      if (shutdown_pin_go) shutdown_pin_cnt_r <= CW'(SHUTDOWN_PIN_CYC + 1);
      else if (shutdown_pin_cnt_r != '0) shutdown_pin_cnt_r <= shutdown_pin_cnt_r - CW'(1);
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wait_cnt_r <= CW'(BOOT_CYC);
      mode_prev_r <= BMM_SHUTDOWN;
    end else begin
      mode_prev_r <= LINK.dev_mode;
      if (back_active && mode_prev_r != BMM_SHUTDOWN) wait_cnt_r <= CW'(WAKE_CYC);
      else if (wait_cnt_r != '0) wait_cnt_r <= wait_cnt_r - CW'(1);
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      stat_r <= 16'h0000;
      dev_sel_r <= 1'b0;
    end else begin
      dev_sel_r <= RD_I & ~own;
      stat_r <= (RD_I && hit_stat) ? stat_val : 16'h0000;
    end
  end
endmodule

// ---- verif/bmm_props.sv ----
// assertion checker on the link between the two mode ends
`timescale 1ns/1ps
module bmm_props import bmm_pkg::*; (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic shutdown_pin,
  input wire logic standby_exit_pin,
  input wire logic comm_on,
  input wire bmm_mode_t dev_mode
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  wire mwr = reg_wr && reg_addr == 8'h01 && !reg_wdata[1] && comm_on;
  wire act = dev_mode == BMM_ACTIVE;
  wire talk = dev_mode inside {BMM_ACTIVE, BMM_LOW_POWER};
  a_comm_by_mode: assert property ($stable(dev_mode) |-> comm_on == talk)
    else $error("comm enable disagrees with mode");
  a_off_read_zero: assert property (reg_rd && !comm_on |=> reg_rdata == 16'h0000)
    else $error("read answered while comms off");
  a_shutdown_pin_sticky: assert property (dev_mode == BMM_SHUTDOWN |=> dev_mode == BMM_SHUTDOWN)
    else $error("left shutdown without reset");
  a_lp_entry: assert property (mwr && act && reg_wdata[3] |-> ##2 dev_mode == BMM_LOW_POWER)
    else $error("low power not entered");
  a_stb_entry: assert property (mwr && act && reg_wdata[4:3] == 2'b10
    |-> ##2 dev_mode == BMM_STANDBY)
    else $error("standby not entered");
  a_slp_entry: assert property (mwr && act && reg_wdata[4:2] == 3'b001
    |-> ##2 dev_mode == BMM_SLEEP)
    else $error("sleep not entered");
  a_lp_exit: assert property (mwr && dev_mode == BMM_LOW_POWER && reg_wdata[4:2] == 3'b000
    |-> ##2 act)
    else $error("low power not left");
  a_sen_exit: assert property ($fell(standby_exit_pin) |-> ##[0:3] dev_mode != BMM_STANDBY)
    else $error("standby kept after exit pulse");
  a_shutdown_pin_pin: assert property ($fell(shutdown_pin) |-> ##[0:3] dev_mode == BMM_SHUTDOWN)
    else $error("shutdown pin ignored");
endmodule

// ---- verif/battery_monitor_mode_fsm_tb.sv ----
// self-checking bench: controller and monitor ends joined by the link
`timescale 1ns/1ps
module battery_monitor_mode_fsm_tb;
  import bmm_pkg::*;
  localparam int WK = 8;
  localparam int SN = 10;
  localparam int SD = 12;
  localparam int BT = 20;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, chg = 0, ld = 1;
  logic wdt = 0, tsd = 0, ov5 = 0, uv5 = 0, uvx = 0, ov18 = 0, ovx = 0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic ready, meas, prot, fet, comm;
  logic [2:0] mode;
  int num_errors = 0;
  int samples_checked = 0;
  bmm_if link ();
  bmm_host #(.SEN_CYC(SN), .SHUTDOWN_PIN_CYC(SD), .WAKE_CYC(WK), .BOOT_CYC(BT)) u_bmm_host (
    .CLK_I(clk), .RSTN_I(rst_n), .LINK(link), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .MEAS_READY_O(ready));
  bmm_device #(.WAKE_CYC(WK), .SEN_CYC(SN), .SHUTDOWN_PIN_CYC(SD)) u_bmm_device (
    .CLK_I(clk), .RSTN_I(rst_n), .LINK(link), .CHARGER_DETECT_PIN_I(chg),
    .LOAD_DETECT_PIN_I(ld), .WDT_TIMEOUT_I(wdt), .THERMAL_SHUTDOWN_I(tsd),
    .OV_SUPPLY_5V5_I(ov5), .OV_SUPPLY_1V8_I(ov18), .UV_SUPPLY_5V5_I(uv5),
    .OV_EXTERNAL_REGULATOR_I(ovx), .UV_EXTERNAL_REGULATOR_I(uvx), .MODE_O(mode),
    .MEAS_EN_O(meas), .PROT_EN_O(prot), .FET_ON_O(fet), .COMM_ON_O(comm));
  bmm_props u_bmm_props (.CLK_I(clk), .RSTN_I(rst_n), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
    .reg_rdata(link.reg_rdata), .shutdown_pin(link.shutdown_pin),
    .standby_exit_pin(link.standby_exit_pin), .comm_on(link.comm_on),
    .dev_mode(link.dev_mode));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic wm(input bmm_mode_t m);
    for (int i = 0; i < 60 && mode !== m; i++) begin
      @(posedge clk);
      #1;
    end
    #1;
    chk({13'h0000, mode}, {13'h0000, m});
    if (mode !== m) end_of_test();
  endtask
  task automatic st(input bmm_mode_t m);
    repeat (WK + 6) @(posedge clk);
    #1;
    chk({13'h0000, mode}, {13'h0000, m});
  endtask
  // charger high or load low, longer than the wake hold
  task automatic pz(input logic c);
    @(posedge clk);
    chg <= c;
    ld <= c;
    repeat (WK + 6) @(posedge clk);
    chg <= 1'b0;
    ld <= 1'b1;
  endtask
  task automatic rst();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({13'h0000, mode}, 16'h0000);
    chk({15'h0000, ready}, 16'h0000);
    rdc(8'h01, 16'h0780);
    rdc(8'h03, 16'h0000);
    rdc(8'h11, 16'h0000);
    rdc(8'h17, 16'h0000);
    rdc(8'h20, 16'h0000);
    rdc(8'h05, 16'h0000);
    $display("reset values done");
    wrr(8'h01, 16'h079c);
    wm(BMM_LOW_POWER);
    rdc(8'h01, 16'h079c);
    wrr(8'h01, 16'h0780);
    wm(BMM_ACTIVE);
    chk({15'h0000, ready}, 16'h0000);
    repeat (WK + 2) @(posedge clk);
    #1;
    chk({15'h0000, ready}, 16'h0001);
    rdc(8'h81, 16'h0020);
    wrr(8'h01, 16'h0794);
    wm(BMM_STANDBY);
    rdc(8'h01, 16'h0000);
    wrr(8'h80, 16'h0001);
    wm(BMM_ACTIVE);
    // sleep request still stands after the standby exit
    wm(BMM_SLEEP);
    pz(1'b1);
    wm(BMM_ACTIVE);
    rdc(8'h01, 16'h0780);
    $display("priority and standby exit done");
    wrr(8'h01, 16'h0788);
    wm(BMM_LOW_POWER);
    pz(1'b0);
    wm(BMM_ACTIVE);
    rdc(8'h01, 16'h0780);
    wrr(8'h01, 16'h0688);
    wm(BMM_LOW_POWER);
    pz(1'b0);
    st(BMM_LOW_POWER);
    wrr(8'h01, 16'h0680);
    wm(BMM_ACTIVE);
    wrr(8'h01, 16'h0790);
    wm(BMM_STANDBY);
    pz(1'b1);
    wm(BMM_ACTIVE);
    rdc(8'h01, 16'h0780);
    $display("low mode wakes done");
    wrr(8'h03, 16'h4321);
    wrr(8'h01, 16'h0784);
    wm(BMM_SLEEP);
    chk({12'h000, meas, prot, fet, comm}, 16'h0000);
    @(posedge clk);
    tsd <= 1'b1;
    st(BMM_SLEEP);
    tsd <= 1'b0;
    pz(1'b0);
    wm(BMM_ACTIVE);
    rdc(8'h03, 16'h4321);
    wrr(8'h01, 16'h0184);
    wm(BMM_SLEEP);
    pz(1'b0);
    st(BMM_SLEEP);
    pz(1'b1);
    wm(BMM_ACTIVE);
    $display("sleep done");
    @(posedge clk);
    chg <= 1'b1;
    wrr(8'h01, 16'h0782);
    st(BMM_ACTIVE);
    wrr(8'h01, 16'h0780);
    chg <= 1'b0;
    wrr(8'h11, 16'h6000);
    wrr(8'h20, 16'h0006);
    wdt <= 1'b1;
    tsd <= 1'b1;
    ov5 <= 1'b1;
    ov18 <= 1'b1;
    ovx <= 1'b1;
    uvx <= 1'b1;
    st(BMM_ACTIVE);
    wdt <= 1'b0;
    tsd <= 1'b0;
    ov5 <= 1'b0;
    ov18 <= 1'b0;
    ovx <= 1'b0;
    uvx <= 1'b0;
    uv5 <= 1'b1;
    wm(BMM_SHUTDOWN);
    rdc(8'h01, 16'h0000);
    uv5 <= 1'b0;
    rst();
    wrr(8'h03, 16'h1000);
    wdt <= 1'b1;
    wm(BMM_SHUTDOWN);
    wdt <= 1'b0;
    rst();
    ov18 <= 1'b1;
    wm(BMM_SHUTDOWN);
    ov18 <= 1'b0;
    rst();
    ovx <= 1'b1;
    wm(BMM_SHUTDOWN);
    ovx <= 1'b0;
    rst();
    wrr(8'h01, 16'h0782);
    wm(BMM_SHUTDOWN);
    rst();
    wrr(8'h80, 16'h0002);
    wm(BMM_SHUTDOWN);
    $display("shutdown causes done");
    end_of_test();
  end
endmodule
